// [rtl/sss_front_end.sv]
// Serial SRAM front end: shifter, status register, pause logic, array.
`timescale 1ns/1ps
`default_nettype none
`include "sss_params.svh"
module sss_front_end #(
    parameter int ADDR_W = 13,
    parameter int DEPTH = `SSS_ARRAY_BYTES,
    parameter int PAGE = `SSS_PAGE_BYTES
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic pause_n_in,
    output logic so_out,
    output logic so_oe_out,
    output logic [7:0] status_out,
    output logic standby_out,
    output logic paused_out
);
    // Page wrap needs a power-of-two page smaller than the array.
    if (DEPTH != (1 << ADDR_W) || PAGE < 2 || PAGE >= DEPTH || (PAGE & (PAGE - 1)) != 0) begin : g_size_check
        $error("sss_front_end: unsupported size parameters");
    end

    localparam int PW = $clog2(PAGE);

    // Two-stage synchronisers; the first stage feeds only the second.
    sss_pkg::sss_pins_t meta, pins, pins_d;
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            meta <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1};
            pins <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1};
            pins_d <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1};
        end else begin
            meta <= '{cs_n: cs_n_in, sck: sck_in, si: si_in, pause_n: pause_n_in};
            pins <= meta;
            pins_d <= pins;
        end
    end

    logic sck_rise, sck_fall, cs_fall;
    assign sck_rise = pins.sck && !pins_d.sck;
    assign sck_fall = !pins.sck && pins_d.sck;
    assign cs_fall = !pins.cs_n && pins_d.cs_n;

    // Array words; the block must remember the whole memory.
    logic [7:0] mem [DEPTH];

    // Next address by mode; shared by reads and writes.
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input sss_pkg::sss_mode_t m);
        logic [ADDR_W-1:0] r;
        r = a + 1'b1;
        if (m == sss_pkg::SSS_MODE_PAGE) begin
            r = {a[ADDR_W-1:PW], r[PW-1:0]};
        end
        // sequential rollover happens through natural counter overflow.
        return r;
    endfunction

    sss_pkg::sss_state_t state, next_state;
    logic [7:0] status, next_status;
    logic [7:0] opcode, next_opcode;
    logic [7:0] shreg, next_shreg;
    logic [15:0] addr_sh, next_addr_sh;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [4:0] bitcnt, next_bitcnt;
    logic [7:0] txreg, next_txreg;
    logic so, next_so;
    logic paused, next_paused;
    logic pause_arm, next_pause_arm;
    logic active, next_active;
    logic wr_en;
    logic [7:0] wr_data;
    sss_pkg::sss_mode_t mode;
    logic pause_en;

    assign mode = sss_sss_mode(status);
    function automatic sss_pkg::sss_mode_t sss_sss_mode(input logic [7:0] s);
        return sss_pkg::sss_mode_t'({s[`SSS_MODE_MSB], s[`SSS_MODE_LSB]});
    endfunction
    // pause honoured only when enable bit is zero.
    assign pause_en = !status[`SSS_PAUSE_DIS_BIT];

    // Next-state logic for the serial sequence, status and pause.
    always_comb begin
        next_state = state;
        next_status = status;
        next_opcode = opcode;
        next_shreg = shreg;
        next_addr_sh = addr_sh;
        next_addr = addr;
        next_bitcnt = bitcnt;
        next_txreg = txreg;
        next_so = so;
        next_paused = paused;
        next_pause_arm = pause_arm;
        next_active = active;
        wr_en = 1'b0;
        wr_data = shreg;
        // leave standby only on a falling chip select.
        if (cs_fall) begin
            next_active = 1'b1;
        end
        if (pins.cs_n) begin
            // deselect aborts and returns to standby.
            next_state = sss_pkg::SSS_ST_IDLE;
            next_active = 1'b0;
            next_paused = 1'b0;
            next_pause_arm = 1'b0;
            next_bitcnt = 5'h00;
        end else if (active || cs_fall) begin
            // pause while clock high waits for the falling edge.
            if (pause_en && !pins.pause_n && !paused) begin
                if (!pins.sck && !sck_fall) begin
                    next_paused = 1'b1;
                end else begin
                    next_pause_arm = 1'b1;
                end
                if (pause_arm && sck_fall) begin
                    next_paused = 1'b1;
                end
            end
            if (pins.pause_n) begin
                next_pause_arm = 1'b0;
            end
            if (paused && pins.pause_n && !pins.sck) begin
                next_paused = 1'b0;
            end
            // while paused nothing shifts and state is kept.
            if (!paused && !(pause_arm && sck_fall) && !(pause_en && !pins.pause_n && !pins.sck)) begin
                if (sck_rise && state != sss_pkg::SSS_ST_DONE) begin
                    // capture MSB first on rising edge.
                    next_shreg = {shreg[6:0], pins.si};
                    next_bitcnt = bitcnt + 5'h01;
                    if (state == sss_pkg::SSS_ST_IDLE) begin
                        next_state = sss_pkg::SSS_ST_CMD;
                    end
                    if (bitcnt == 5'h07 && state != sss_pkg::SSS_ST_ADDR) begin
                        next_bitcnt = 5'h00;
                        if (state == sss_pkg::SSS_ST_DATA) begin
                            if (opcode == `SSS_OP_WRITE_STATUS) begin
                                next_status = ({shreg[6:0], pins.si} & `SSS_STATUS_WMASK) | `SSS_STATUS_FIXED_ONE;
                                next_state = sss_pkg::SSS_ST_DONE;
                            end else if (opcode == `SSS_OP_WRITE) begin
                                wr_en = 1'b1;
                                wr_data = {shreg[6:0], pins.si};
                                next_addr = step_addr(addr, mode);
                                if (mode == sss_pkg::SSS_MODE_BYTE) begin
                                    next_state = sss_pkg::SSS_ST_DONE;
                                end
                            end else begin
                                next_addr = step_addr(addr, mode);
                                if (mode == sss_pkg::SSS_MODE_BYTE || opcode == `SSS_OP_READ_STATUS) begin
                                    next_state = sss_pkg::SSS_ST_DONE;
                                end
                            end
                        end else begin
                            next_opcode = {shreg[6:0], pins.si};
                            if (next_opcode == `SSS_OP_READ || next_opcode == `SSS_OP_WRITE) begin
                                next_state = sss_pkg::SSS_ST_ADDR;
                            end else if (next_opcode == `SSS_OP_READ_STATUS || next_opcode == `SSS_OP_WRITE_STATUS) begin
                                next_state = sss_pkg::SSS_ST_DATA;
                            end else begin
                                next_state = sss_pkg::SSS_ST_DONE;
                            end
                        end
                    end
                    if (state == sss_pkg::SSS_ST_ADDR) begin
                        next_addr_sh = {addr_sh[14:0], pins.si};
                        if (bitcnt == 5'h0f) begin
                            next_bitcnt = 5'h00;
                            next_addr = next_addr_sh[ADDR_W-1:0];
                            next_state = sss_pkg::SSS_ST_DATA;
                        end
                    end
                end
                // output moves only after a falling clock edge.
                if (sck_fall && state == sss_pkg::SSS_ST_DATA) begin
                    if (bitcnt == 5'h00) begin
                        next_txreg = (opcode == `SSS_OP_READ_STATUS) ? status : mem[addr];
                        next_so = next_txreg[7];
                        next_txreg = {next_txreg[6:0], 1'b0};
                    end else begin
                        next_so = txreg[7];
                        next_txreg = {txreg[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // State registers; status resets to byte mode with pause enabled.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state <= sss_pkg::SSS_ST_IDLE;
            status <= `SSS_STATUS_RESET;
            opcode <= 8'h00;
            shreg <= 8'h00;
            addr_sh <= 16'h0000;
            addr <= '0;
            bitcnt <= 5'h00;
            txreg <= 8'h00;
            so <= 1'b0;
            paused <= 1'b0;
            pause_arm <= 1'b0;
            active <= 1'b0;
        end else begin
            state <= next_state;
            status <= next_status;
            opcode <= next_opcode;
            shreg <= next_shreg;
            addr_sh <= next_addr_sh;
            addr <= next_addr;
            bitcnt <= next_bitcnt;
            txreg <= next_txreg;
            so <= next_so;
            paused <= next_paused;
            pause_arm <= next_pause_arm;
            active <= next_active;
        end
    end

    // Array write port; no reset since contents are undefined at power-up.
    always_ff @(posedge mclk_in) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    logic reading;
    assign reading = (opcode == `SSS_OP_READ || opcode == `SSS_OP_READ_STATUS)
        && (state == sss_pkg::SSS_ST_DATA || state == sss_pkg::SSS_ST_DONE);
    // output floats when deselected or pause pin low, whatever the enable bit.
    assign so_oe_out = active && !pins.cs_n && pins.pause_n && !paused && reading;
    assign so_out = so;
    assign status_out = status;
    assign standby_out = !active;
    assign paused_out = paused;

    // Status always reads back fixed bits.
    // fixed bits
    a_status_fixed: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        status[5:1] == 5'h01) else $error("status fixed bits wrong");
    a_cs_float: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cs_n_in |-> ##2 !so_oe_out) else $error("output driven while deselected");
    a_pause_float: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !pause_n_in |-> ##2 !so_oe_out) else $error("output driven while pause low");
    a_so_edge: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        so != $past(so) |-> $past(sck_fall)) else $error("output changed off a falling edge");
    a_pause_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        paused && $past(paused) && !pins.cs_n |-> $stable(bitcnt) && $stable(state))
        else $error("sequence moved while paused");
    a_pause_dis: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !paused && status[0] |=> !paused) else $error("paused although pause disabled");
    a_resume_low: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        $fell(paused) && !pins.cs_n |-> !$past(pins.sck)) else $error("resumed with clock high");
    a_standby: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        pins.cs_n |=> standby_out) else $error("not in standby after deselect");
    a_status_wr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        status != $past(status) |-> $past(opcode) == `SSS_OP_WRITE_STATUS) else $error("status changed without write");
endmodule // sss_front_end
`default_nettype wire

// [shared/sss_params.svh]
// Constants for the serial SRAM status and pause front end.
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
`define SSS_OP_READ_STATUS 8'h05
`define SSS_OP_WRITE_STATUS 8'h01
`define SSS_OP_READ 8'h03
`define SSS_OP_WRITE 8'h02
`define SSS_STATUS_RESET 8'h02
`define SSS_STATUS_FIXED_ONE 8'h02
`define SSS_STATUS_WMASK 8'hc1
`define SSS_MODE_MSB 7
`define SSS_MODE_LSB 6
`define SSS_PAUSE_DIS_BIT 0
`define SSS_PAGE_BYTES 32
`define SSS_ARRAY_BYTES 8192
`endif

// [shared/sss_pkg.sv]
// Types shared by the serial SRAM status and pause front end.
package sss_pkg;
    typedef enum logic [1:0] {
        SSS_MODE_BYTE = 2'h0,
        SSS_MODE_SEQ = 2'h1,
        SSS_MODE_PAGE = 2'h2,
        SSS_MODE_RSVD = 2'h3
    } sss_mode_t;
    typedef enum logic [4:0] {
        SSS_ST_IDLE = 5'h01,
        SSS_ST_CMD = 5'h02,
        SSS_ST_ADDR = 5'h04,
        SSS_ST_DATA = 5'h08,
        SSS_ST_DONE = 5'h10
    } sss_state_t;
    // Synchronised pin levels.
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic pause_n;
    } sss_pins_t;
endpackage

// [tb/sss_host_model.sv]
// Host serial master model that drives the front end pins in mode 0.
`timescale 1ns/1ps
`default_nettype none
module sss_host_model (
    input wire logic mclk_in,
    input wire logic so_in,
    input wire logic so_oe_in,
    input wire logic paused_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out,
    output logic pause_n_out
);
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        pause_n_out = 1'b1;
    end

    // Select or deselect; data in is scrambled while deselected so no stale level is trusted.
    task automatic sel(input bit on);
        sck_out = 1'b0;
        repeat (4) @(negedge mclk_in);
        cs_n_out = ~on;
        if (!on) si_out = ~si_out;
        repeat (6) @(negedge mclk_in);
    endtask

    // Pause sequence; with the clock high the host must wait for its fall before the pause counts.
    task automatic hold(input bit hi, input bit en);
        // A pause in the low phase comes after the fall has been seen, so that fall still moves the output.
        if (!hi) repeat (4) @(negedge mclk_in);
        pause_n_out = 1'b0;
        repeat (3) @(negedge mclk_in);
        if (hi) testbench.check({7'h0, paused_in}, 8'h00);
        if (hi) sck_out = 1'b0;
        repeat (5) @(negedge mclk_in);
        testbench.check({7'h0, paused_in}, {7'h0, en});
        testbench.check({7'h0, so_oe_in}, 8'h00);
        if (en) begin
            repeat (4) begin
                sck_out = ~sck_out;
                si_out = ~si_out;
                repeat (2) @(negedge mclk_in);
            end
        end
        pause_n_out = 1'b1;
        repeat (5) @(negedge mclk_in);
        testbench.check({7'h0, paused_in}, 8'h00);
    endtask

    // One byte or its first nb bits; output is read late in the low phase, well after the fall.
    task automatic xfer(input logic [7:0] tx, input int nb, input int pi, input bit hi, input bit en,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            sck_out = 1'b0;
            if (i == pi && !hi) hold(1'b0, en);
            si_out = tx[i];
            repeat (5) @(negedge mclk_in);
            rx[i] = so_in;
            sck_out = 1'b1;
            if (i == pi && hi) hold(1'b1, en);
            repeat (3) @(negedge mclk_in);
        end
    endtask
endmodule // sss_host_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the serial SRAM status and pause front end.
`timescale 1ns/1ps
`default_nettype none
`include "sss_params.svh"
module testbench;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic cs_n, sck, si, pause_n;
    logic so_out, so_oe_out, standby_out, paused_out;
    logic [7:0] status_out;
    logic [7:0] cur;
    logic [7:0] rx;
    logic [7:0] wb;
    logic [7:0] dat [3];
    logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h1};
    int errors = 0;
    int samples_checked = 0;

    // Free-running 100 MHz system clock.
    always #5 mclk_in = ~mclk_in;

    sss_front_end sss_front_end_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .cs_n_in(cs_n), .sck_in(sck),
        .si_in(si), .pause_n_in(pause_n), .so_out(so_out), .so_oe_out(so_oe_out), .status_out(status_out),
        .standby_out(standby_out), .paused_out(paused_out));

    sss_host_model sss_host_model_inst (.mclk_in(mclk_in), .so_in(so_out), .so_oe_in(so_oe_out),
        .paused_in(paused_out), .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .pause_n_out(pause_n));

    // Single comparison point for every byte or flag result.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Only mode and pause-enable bits stick; bit 1 always reads as one.
    function automatic logic [7:0] status_after(input logic [7:0] b);
        return (b & `SSS_STATUS_WMASK) | `SSS_STATUS_FIXED_ONE;
    endfunction

    // Read-status frame, optionally paused in the low phase of bit pi of the answer.
    task automatic rd_status(input int pi);
        sss_host_model_inst.sel(1'b1);
        sss_host_model_inst.xfer(`SSS_OP_READ_STATUS, 8, -1, 1'b0, ~cur[0], rx);
        sss_host_model_inst.xfer(8'($urandom), 8, pi, 1'b0, ~cur[0], rx);
        check(rx, cur);
        check({7'h0, so_oe_out}, 8'h01);
        sss_host_model_inst.sel(1'b0);
        check({6'h0, standby_out, so_oe_out}, 8'h02);
        $display("read test done at %0t ns", $time);
    endtask

    // Write-status frame of nb data bits, optionally paused in the high phase of bit pi.
    task automatic wr_status(input logic [7:0] b, input int nb, input int pi);
        sss_host_model_inst.sel(1'b1);
        sss_host_model_inst.xfer(`SSS_OP_WRITE_STATUS, 8, -1, 1'b1, ~cur[0], rx);
        // A pause on the last bit only bites after that bit has loaded the new enable.
        sss_host_model_inst.xfer(b, nb, pi, 1'b1, (pi == 0) ? ~b[0] : ~cur[0], rx);
        sss_host_model_inst.sel(1'b0);
        if (nb == 8) cur = status_after(b);
        check(status_out, cur);
        $display("write test done at %0t ns", $time);
    endtask

    // Array write of n random bytes from address a, then one byte read back from address zero.
    task automatic arr_test(input logic [15:0] a, input int n);
        for (int j = 0; j < n; j++) begin
            dat[j] = 8'($urandom);
        end
        sss_host_model_inst.sel(1'b1);
        sss_host_model_inst.xfer(`SSS_OP_WRITE, 8, -1, 1'b0, 1'b0, rx);
        sss_host_model_inst.xfer(a[15:8], 8, -1, 1'b0, 1'b0, rx);
        sss_host_model_inst.xfer(a[7:0], 8, -1, 1'b0, 1'b0, rx);
        for (int j = 0; j < n; j++) begin
            sss_host_model_inst.xfer(dat[j], 8, -1, 1'b0, 1'b0, rx);
        end
        sss_host_model_inst.sel(1'b0);
        sss_host_model_inst.sel(1'b1);
        sss_host_model_inst.xfer(`SSS_OP_READ, 8, -1, 1'b0, 1'b0, rx);
        sss_host_model_inst.xfer(8'h00, 8, -1, 1'b0, 1'b0, rx);
        sss_host_model_inst.xfer(8'h00, 8, -1, 1'b0, 1'b0, rx);
        sss_host_model_inst.xfer(8'h00, 8, -1, 1'b0, 1'b0, rx);
        sss_host_model_inst.sel(1'b0);
        check(rx, dat[n - 1]);
        $display("array test done at %0t ns", $time);
    endtask

    // Verdict and end of run.
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence: reset, byte, page and sequential modes, pauses, a partial byte.
    initial begin
        void'($urandom(20443));
        cur = `SSS_STATUS_RESET;
        repeat (6) @(negedge mclk_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        check(status_out, 8'h02);
        check({6'h0, standby_out, so_oe_out}, 8'h02);
        rd_status(-1);
        for (int k = 0; k < 6; k++) begin
            wb = {modes[k % 3], 5'h00, 1'($urandom)};
            wr_status(wb, 8, (k < 3) ? -1 : int'($urandom_range(7, 0)));
            rd_status((k < 3) ? -1 : int'($urandom_range(7, 0)));
        end
        wr_status(8'hc0, 4, -1);
        wr_status(8'h80, 8, 3);
        rd_status(5);
        wr_status(8'h41, 8, 0);
        rd_status(7);
        // The last byte must land at address zero only if the counter wraps or rolls over.
        wr_status(8'h80, 8, -1);
        arr_test(16'h001e, 3);
        wr_status(8'h40, 8, -1);
        arr_test(16'h1fff, 2);
        results();
    end

    // Watchdog well beyond the expected run of about 45 us.
    initial begin
        #400000;
        errors++;
        results();
    end
endmodule // testbench
`default_nettype wire
